// File: rtl/cls_pkg.sv
`default_nettype none
package cls_pkg;

   localparam int DATA_W = 32;
   localparam int WAYS = 4;

   // Register byte offsets on the Avalon-MM slave.
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_REGION0 = 4'h4;
   localparam logic [3:0] REG_REGION1 = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'hc;

   // Control register fields.
   localparam int CTRL_DFLT_MODE_LSB = 0;
   localparam int CTRL_DPKV_BIT = 2;
   localparam int CTRL_IPKV_BIT = 3;
   localparam int CTRL_DINV_BIT = 4;
   localparam int CTRL_IINV_BIT = 5;

   // Region access control fields.
   localparam int RG_MODE_LSB = 5;
   localparam int RG_EN_BIT = 15;
   localparam int RG_MASK_LSB = 16;
   localparam int RG_BASE_LSB = 24;

   localparam logic [31:0] REGION_RESET = 32'h0000_0000;

   typedef enum logic [1:0] {
      MODE_WT = 2'b00,
      MODE_CB = 2'b01,
      MODE_INH_PRECISE = 2'b10,
      MODE_INH_IMPRECISE = 2'b11
   } cache_mode_e;

   typedef enum logic [1:0] {
      OP_READ = 2'b00,
      OP_WRITE = 2'b01,
      OP_INVALIDATE = 2'b10,
      OP_PUSH = 2'b11
   } core_op_e;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_FILL = 3'b001,
      S_PUSH = 3'b010,
      S_THRU = 3'b011,
      S_BYPASS = 3'b100,
      S_RESP = 3'b101
   } fsm_e;

   typedef struct packed {
      logic read;
      logic write;
      logic [3:0] address;
      logic [31:0] writedata;
   } av_req_s;

   typedef struct packed {
      logic valid;
      logic instr;
      core_op_e op;
      logic [1:0] way;
      logic [31:0] addr;
      logic [31:0] wdata;
   } core_req_s;

   typedef struct packed {
      logic valid;
      logic [31:0] rdata;
   } core_resp_s;

   typedef struct packed {
      logic valid;
      logic write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } mem_req_s;

   typedef struct packed {
      logic valid;
      logic modified;
      logic [29:0] tag;
      logic [31:0] data;
   } line_s;

   typedef struct packed {
      fsm_e state;
      logic [1:0] default_data_cache_mode;
      logic dpkv;
      logic ipkv;
      logic dinv;
      logic iinv;
      logic [31:0] region0;
      logic [31:0] region1;
      logic av_wait;
      logic [31:0] av_rdata;
      logic core_ready;
      core_resp_s resp;
      mem_req_s mem;
      logic instr;
      logic is_write;
      logic [1:0] way;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic pb_pending;
      logic [31:0] pb_addr;
      logic [31:0] pb_data;
      logic last_hit;
      logic [1:0] last_state;
   } st_s;

   localparam st_s ST_RESET = '{state: S_IDLE, default_data_cache_mode: 2'h0, dpkv: 1'b0, ipkv: 1'b0, dinv: 1'b0,
      iinv: 1'b0, region0: REGION_RESET, region1: REGION_RESET, av_wait: 1'b1, av_rdata: 32'h0,
      core_ready: 1'b1, resp: '0, mem: '0, instr: 1'b0, is_write: 1'b0, way: 2'h0, addr: 32'h0,
      wdata: 32'h0, pb_pending: 1'b0, pb_addr: 32'h0, pb_data: 32'h0, last_hit: 1'b0,
      last_state: 2'h0};

endpackage
`default_nettype wire

// File: rtl/victim_pointer.sv
`timescale 1ns/10ps
`default_nettype none
module victim_pointer (
   input wire logic sys_clk, // Core clock.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic advance, // Pulse when a miss picks a valid line to replace.
   output logic [1:0] ptr // Way to replace next.
);
   typedef struct packed {
      logic [1:0] ptr;
   } vp_s;

   vp_s q, d;

   always_comb begin
      d = q;
      if (advance) begin
         d.ptr = q.ptr + 2'h1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign ptr = q.ptr;
endmodule
`default_nettype wire

// File: rtl/line_mem.sv
`timescale 1ns/10ps
`default_nettype none
module line_mem #(
   parameter int SETS = 128
) (
   input wire logic sys_clk, // Core clock.
   input wire logic [$clog2(SETS)-1:0] set_idx, // Set read and written.
   output cls_pkg::line_s [3:0] lines, // All ways of the set.
   input wire logic wr_en, // Write one line.
   input wire logic [1:0] wr_way, // Way written.
   input wire cls_pkg::line_s wr_line, // Line written.
   input wire logic clr_all // Clear every valid bit.
);
   import cls_pkg::*;

   if (SETS < 2 || (1 << $clog2(SETS)) != SETS) begin : g_chk
      $error("Set count must be a power of two of at least 2.");
   end

   // Tags, state and data have no reset: reset leaves the cache contents alone.
   line_s mem [SETS][WAYS];

   always_ff @(posedge sys_clk) begin
      if (clr_all) begin
         for (int s = 0; s < SETS; s++) begin
            for (int w = 0; w < WAYS; w++) begin
               mem[s][w].valid <= 1'b0;
            end
         end
      end else if (wr_en) begin
         mem[set_idx][wr_way] <= wr_line;
      end
   end

   always_comb begin
      for (int w = 0; w < WAYS; w++) begin
         lines[w] = mem[set_idx][w];
      end
   end
endmodule
`default_nettype wire

// File: rtl/cache_line_state_control.sv
// Chosen here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module cache_line_state_control #(
   parameter int I_SETS = 256,
   parameter int D_SETS = 128
) (
   input wire logic sys_clk, // Core clock, 250 MHz.
   input wire logic rst, // Asynchronous reset, active high.
   input wire cls_pkg::av_req_s av_req, // Avalon-MM request.
   output logic [31:0] av_readdata, // Avalon-MM read data.
   output logic av_waitrequest, // Avalon-MM wait request.
   input wire cls_pkg::core_req_s core_req, // Core cache request.
   output logic core_ready, // Core request is taken.
   output cls_pkg::core_resp_s core_resp, // Core answer pulse.
   output cls_pkg::mem_req_s mem_req, // Memory request.
   input wire logic mem_ack, // Memory completes request.
   input wire logic [31:0] mem_rdata // Memory read data.
);
   import cls_pkg::*;

   localparam int IB = $clog2(I_SETS);
   localparam int DB = $clog2(D_SETS);

   if (I_SETS < 2 || D_SETS < 2 || (1 << IB) != I_SETS || (1 << DB) != D_SETS || IB > 29 || DB > 29) begin : g_chk
      $error("Set counts must be powers of two between 2 and 2**29.");
   end

   st_s q, d;
   line_s [3:0] i_lines, d_lines, lines;
   line_s lw_line, cur;
   logic lw_i, lw_d, clr_i, clr_d, adv_i, adv_d, take, hit;
   logic [1:0] lw_way, hway, vway, i_ptr, d_ptr;
   logic [31:0] idx_addr;
   cache_mode_e mode;

   function automatic cache_mode_e mode_for(input logic [31:0] a, input logic [31:0] r0,
                                           input logic [31:0] r1, input logic [1:0] dflt);
      cache_mode_e m;
      m = cache_mode_e'(dflt);
      if (r1[RG_EN_BIT] && (((a[31:24] ^ r1[RG_BASE_LSB +: 8]) & ~r1[RG_MASK_LSB +: 8]) == 8'h00)) begin
         m = cache_mode_e'(r1[RG_MODE_LSB +: 2]);
      end
      if (r0[RG_EN_BIT] && (((a[31:24] ^ r0[RG_BASE_LSB +: 8]) & ~r0[RG_MASK_LSB +: 8]) == 8'h00)) begin
         m = cache_mode_e'(r0[RG_MODE_LSB +: 2]);
      end
      return m;
   endfunction

   function automatic line_s make_line(input logic v, input logic m, input logic [29:0] t,
                                       input logic [31:0] dat);
      line_s l;
      l.valid = v;
      l.modified = m;
      l.tag = t;
      l.data = dat;
      return l;
   endfunction

   function automatic logic [31:0] reg_read(input logic [3:0] a, input st_s s);
      logic [31:0] r;
      r = 32'h0;
      case (a)
         REG_CTRL: begin
            r[CTRL_DFLT_MODE_LSB +: 2] = s.default_data_cache_mode;
            r[CTRL_DPKV_BIT] = s.dpkv;
            r[CTRL_IPKV_BIT] = s.ipkv;
            r[CTRL_DINV_BIT] = s.dinv;
            r[CTRL_IINV_BIT] = s.iinv;
         end
         REG_REGION0: r = s.region0;
         REG_REGION1: r = s.region1;
         REG_STATUS: r = {28'h0, s.last_hit, s.last_state, s.state != S_IDLE};
         default: r = 32'h0;
      endcase
      return r;
   endfunction

   assign idx_addr = (q.state == S_IDLE) ? core_req.addr : q.addr;

   line_mem #(.SETS(I_SETS)) u_imem (
      .sys_clk(sys_clk),
      .set_idx(idx_addr[IB+1:2]),
      .lines(i_lines),
      .wr_en(lw_i),
      .wr_way(lw_way),
      .wr_line(lw_line),
      .clr_all(clr_i)
   );

   line_mem #(.SETS(D_SETS)) u_dmem (
      .sys_clk(sys_clk),
      .set_idx(idx_addr[DB+1:2]),
      .lines(d_lines),
      .wr_en(lw_d),
      .wr_way(lw_way),
      .wr_line(lw_line),
      .clr_all(clr_d)
   );

   victim_pointer u_ivp (
      .sys_clk(sys_clk),
      .rst(rst),
      .advance(adv_i),
      .ptr(i_ptr)
   );

   victim_pointer u_dvp (
      .sys_clk(sys_clk),
      .rst(rst),
      .advance(adv_d),
      .ptr(d_ptr)
   );

   assign lines = core_req.instr ? i_lines : d_lines;
   assign mode = mode_for(core_req.addr, q.region0, q.region1, q.default_data_cache_mode);
   assign take = (q.state == S_IDLE) && q.core_ready && core_req.valid;

   always_comb begin
      hit = 1'b0;
      hway = 2'h0;
      vway = core_req.instr ? i_ptr : d_ptr;
      for (int w = WAYS - 1; w >= 0; w--) begin
         if (lines[w].valid && lines[w].tag == core_req.addr[31:2]) begin
            hit = 1'b1;
            hway = 2'(w);
         end
      end
      for (int w = WAYS - 1; w >= 0; w--) begin
         if (!lines[w].valid) begin
            vway = 2'(w);
         end
      end
   end

   always_comb begin
      d = q;
      d.resp.valid = 1'b0;
      lw_i = 1'b0;
      lw_d = 1'b0;
      lw_way = 2'h0;
      lw_line = '0;
      clr_i = 1'b0;
      clr_d = 1'b0;
      adv_i = 1'b0;
      adv_d = 1'b0;
      cur = '0;
      if (q.mem.valid && mem_ack) begin
         d.mem.valid = 1'b0;
      end
      case (q.state)
         S_IDLE: begin
            if (take) begin
               d.instr = core_req.instr;
               d.addr = core_req.addr;
               d.wdata = core_req.wdata;
               d.is_write = (core_req.op == OP_WRITE);
               d.core_ready = 1'b0;
               d.state = S_RESP;
               d.last_hit = hit;
               lw_way = hit ? hway : vway;
               cur = lines[lw_way];
               d.last_state = {cur.valid, cur.modified & ~core_req.instr};
               case (core_req.op)
                  OP_READ, OP_WRITE: begin
                     if (core_req.instr && core_req.op == OP_WRITE) begin
                        d.state = S_RESP;
                     end else if (!core_req.instr && mode[1]) begin
                        d.mem = '{valid: 1'b1, write: d.is_write, addr: core_req.addr, wdata: core_req.wdata};
                        d.state = d.is_write ? S_THRU : S_BYPASS;
                     end else if (hit && !d.is_write) begin
                        d.resp.rdata = cur.data;
                     end else if (hit && mode == MODE_CB) begin
                        lw_d = 1'b1;
                        lw_line = make_line(1'b1, 1'b1, cur.tag, core_req.wdata);
                     end else if (hit) begin
                        lw_d = 1'b1;
                        lw_line = make_line(1'b1, 1'b0, cur.tag, core_req.wdata);
                        d.mem = '{valid: 1'b1, write: 1'b1, addr: core_req.addr, wdata: core_req.wdata};
                        d.state = S_THRU;
                     end else if (d.is_write && mode == MODE_WT) begin
                        d.mem = '{valid: 1'b1, write: 1'b1, addr: core_req.addr, wdata: core_req.wdata};
                        d.state = S_THRU;
                     end else begin
                        d.way = vway;
                        if (cur.valid) begin
                           adv_i = core_req.instr;
                           adv_d = !core_req.instr;
                        end
                        if (!core_req.instr && cur.valid && cur.modified) begin
                           d.pb_pending = 1'b1;
                           d.pb_addr = {cur.tag, 2'b00};
                           d.pb_data = cur.data;
                        end
                        d.mem = '{valid: 1'b1, write: 1'b0, addr: core_req.addr, wdata: 32'h0};
                        d.state = S_FILL;
                     end
                  end
                  OP_INVALIDATE: begin
                     lw_way = core_req.way;
                     cur = lines[core_req.way];
                     lw_i = core_req.instr;
                     lw_d = !core_req.instr;
                     lw_line = make_line(1'b0, 1'b0, cur.tag, cur.data);
                  end
                  default: begin
                     lw_way = core_req.way;
                     cur = lines[core_req.way];
                     lw_i = core_req.instr;
                     lw_d = !core_req.instr;
                     lw_line = make_line(cur.valid & (core_req.instr ? q.ipkv : q.dpkv), 1'b0,
                                         cur.tag, cur.data);
                     if (!core_req.instr && cur.valid && cur.modified) begin
                        d.mem = '{valid: 1'b1, write: 1'b1, addr: {cur.tag, 2'b00}, wdata: cur.data};
                        d.state = S_PUSH;
                     end
                  end
               endcase
            end else if (q.iinv || q.dinv) begin
               clr_i = q.iinv;
               clr_d = q.dinv;
               d.iinv = 1'b0;
               d.dinv = 1'b0;
            end
         end
         S_FILL: begin
            if (q.mem.valid && mem_ack) begin
               lw_way = q.way;
               lw_i = q.instr;
               lw_d = !q.instr;
               lw_line = make_line(1'b1, q.is_write, q.addr[31:2],
                                   q.is_write ? q.wdata : mem_rdata);
               d.resp.rdata = mem_rdata;
               d.state = S_RESP;
               if (q.pb_pending) begin
                  d.pb_pending = 1'b0;
                  d.mem = '{valid: 1'b1, write: 1'b1, addr: q.pb_addr, wdata: q.pb_data};
                  d.state = S_PUSH;
               end
            end
         end
         S_PUSH, S_THRU: begin
            if (q.mem.valid && mem_ack) begin
               d.state = S_RESP;
            end
         end
         S_BYPASS: begin
            if (q.mem.valid && mem_ack) begin
               d.resp.rdata = mem_rdata;
               d.state = S_RESP;
            end
         end
         S_RESP: begin
            d.resp.valid = 1'b1;
            d.core_ready = 1'b1;
            d.state = S_IDLE;
         end
         default: begin
            d.state = S_IDLE;
            d.core_ready = 1'b1;
         end
      endcase
      // Software writes come last so a set of an invalidate bit beats the hardware clear.
      if (av_req.read || av_req.write) begin
         if (q.av_wait) begin
            d.av_wait = 1'b0;
            d.av_rdata = reg_read(av_req.address, q);
         end else begin
            d.av_wait = 1'b1;
            if (av_req.write) begin
               case (av_req.address)
                  REG_CTRL: begin
                     d.default_data_cache_mode = av_req.writedata[CTRL_DFLT_MODE_LSB +: 2];
                     d.dpkv = av_req.writedata[CTRL_DPKV_BIT];
                     d.ipkv = av_req.writedata[CTRL_IPKV_BIT];
                     d.dinv = q.dinv | d.dinv | av_req.writedata[CTRL_DINV_BIT];
                     d.iinv = q.iinv | d.iinv | av_req.writedata[CTRL_IINV_BIT];
                  end
                  REG_REGION0: d.region0 = av_req.writedata;
                  REG_REGION1: d.region1 = av_req.writedata;
                  default: d.av_wait = 1'b1;
               endcase
            end
         end
      end else begin
         d.av_wait = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         q <= ST_RESET;
      end else begin
         q <= d;
      end
   end

   assign av_readdata = q.av_rdata;
   assign av_waitrequest = q.av_wait;
   assign core_ready = q.core_ready;
   assign core_resp = q.resp;
   assign mem_req = q.mem;
endmodule
`default_nettype wire

// File: test/cls_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module cls_assertions
   import cls_pkg::*;
#(
   parameter int I_SETS = 256,
   parameter int D_SETS = 128
) (
   input wire logic sys_clk, // Clock.
   input wire logic rst, // Reset.
   input wire cls_pkg::av_req_s av_req, // Bus request.
   input wire logic [31:0] av_readdata, // Bus read data.
   input wire logic av_waitrequest, // Bus wait.
   input wire cls_pkg::core_req_s core_req, // Core request.
   input wire logic core_ready, // Core taken.
   input wire cls_pkg::core_resp_s core_resp, // Core answer.
   input wire cls_pkg::mem_req_s mem_req, // Memory request.
   input wire logic mem_ack, // Memory done.
   input wire logic [31:0] mem_rdata // Memory data.
);
   import cls_pkg::*;
   wire logic take;
   assign take = core_req.valid && core_ready;
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (rst);
   chk_av_one_wait: assert property (
      (av_req.read || av_req.write) && av_waitrequest |=> !av_waitrequest)
      else $error("bus access not answered after one wait cycle");
   chk_av_release: assert property (
      !av_waitrequest |=> av_waitrequest)
      else $error("bus answer stood longer than one cycle");
   chk_av_unmapped: assert property (
      av_req.read && av_waitrequest && av_req.address[1:0] != 2'h0 |=> av_readdata == 32'h0)
      else $error("unmapped read returned nonzero data");
   chk_core_busy: assert property (
      take |=> !core_ready)
      else $error("core port still ready after a take");
   chk_resp_pulse: assert property (
      core_resp.valid |=> !core_resp.valid)
      else $error("core answer longer than one cycle");
   chk_resp_bound: assert property (
      take |-> ##[2:60] core_resp.valid)
      else $error("core request not answered in time");
   chk_icache_write: assert property (
      take && core_req.instr && core_req.op == OP_WRITE |=> !mem_req.valid ##1 core_resp.valid)
      else $error("instruction write caused traffic or a late answer");
   chk_inval_quiet: assert property (
      take && core_req.op == OP_INVALIDATE |=> !mem_req.valid ##1 (core_resp.valid && !mem_req.valid))
      else $error("invalidate touched memory or answered late");
   chk_mem_hold: assert property (
      mem_req.valid && !mem_ack |=> mem_req.valid && $stable(mem_req))
      else $error("memory request changed before its acknowledge");
   chk_mem_drop: assert property (
      mem_req.valid && mem_ack && mem_req.write |=> !mem_req.valid)
      else $error("memory write request stayed after acknowledge");
endmodule
bind cache_line_state_control cls_assertions #(.I_SETS(I_SETS), .D_SETS(D_SETS)) cls_assertions_i (
   .sys_clk(sys_clk), .rst(rst), .av_req(av_req), .av_readdata(av_readdata),
   .av_waitrequest(av_waitrequest), .core_req(core_req), .core_ready(core_ready),
   .core_resp(core_resp), .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
`default_nettype wire

// File: test/mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module mem_model (
   input wire logic sys_clk, // Clock.
   input wire logic rst, // Reset.
   input wire cls_pkg::mem_req_s mem_req, // Request.
   input wire logic slow, // Four-cycle answers.
   output logic mem_ack, // Done.
   output logic [31:0] mem_rdata // Read data.
);
   import cls_pkg::*;
   logic [31:0] words [logic [31:0]];
   logic [32:0] hist [$];
   logic [1:0] cnt;
   // Outside an answer the data lines toggle so stale data cannot pass as valid.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mem_ack <= 1'b0;
         cnt <= 2'h0;
         mem_rdata <= 32'h0;
      end else if (mem_ack || !mem_req.valid) begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
      end else if (cnt != {slow, slow}) begin
         cnt <= cnt + 2'h1;
         mem_rdata <= ~mem_rdata;
      end else begin
         cnt <= 2'h0;
         mem_ack <= 1'b1;
         hist.push_back({mem_req.write, mem_req.addr});
         if (mem_req.write) begin
            words[mem_req.addr] = mem_req.wdata;
         end else begin
            mem_rdata <= words.exists(mem_req.addr) ? words[mem_req.addr] : 32'hd000_0000 + mem_req.addr;
         end
      end
   end
endmodule
`default_nettype wire

// File: test/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
   import cls_pkg::*;
   localparam logic [31:0] A = 32'h10, B = 32'h20, C = 32'h30, D = 32'h40, E = 32'h50, F = 32'h60;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic slow = 1'b0;
   av_req_s av_req = '0;
   core_req_s core_req = '0;
   logic [31:0] av_readdata, mem_rdata, rd, a;
   logic av_waitrequest, core_ready, mem_ack;
   core_resp_s core_resp;
   mem_req_s mem_req;
   int fails = 0;
   int cmp_count = 0;
   always #2 sys_clk = ~sys_clk;
   cache_line_state_control #(.I_SETS(4), .D_SETS(4)) cache_line_state_control_i (.sys_clk(sys_clk),
      .rst(rst), .av_req(av_req), .av_readdata(av_readdata), .av_waitrequest(av_waitrequest),
      .core_req(core_req), .core_ready(core_ready), .core_resp(core_resp), .mem_req(mem_req),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   mem_model mem_model_i (.sys_clk(sys_clk), .rst(rst), .mem_req(mem_req), .slow(slow),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   task automatic complete_run();
      if (fails == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bound(input int n);
      if (n >= 200) begin
         fails++;
         complete_run();
      end
   endtask
   task automatic acc(input logic wr, input logic [3:0] ad, input logic [31:0] wd);
      int n;
      @(posedge sys_clk);
      av_req <= '{read: !wr, write: wr, address: ad, writedata: wd};
      // Wait request and read data are taken at the rising edge that ends the access.
      @(posedge sys_clk);
      for (n = 0; n < 200 && av_waitrequest; n++) @(posedge sys_clk);
      bound(n);
      rd = av_readdata;
      av_req <= '0;
   endtask
   task automatic op(input logic ins, input core_op_e o, input logic [1:0] w, input logic [31:0] ad,
         input logic [31:0] wd);
      int n;
      @(posedge sys_clk);
      core_req <= '{valid: 1'b1, instr: ins, op: o, way: w, addr: ad, wdata: wd};
      @(posedge sys_clk);
      for (n = 0; n < 200 && !core_ready; n++) @(posedge sys_clk);
      bound(n);
      core_req <= '0;
      @(posedge sys_clk);
      for (n = 0; n < 200 && !core_resp.valid; n++) @(posedge sys_clk);
      bound(n);
      rd = core_resp.rdata;
   endtask
   // Expected status bits are {hit, valid, modified} of the line before the access.
   task automatic sc(input logic [2:0] e);
      acc(0, REG_STATUS, 0);
      chk(rd[3:1], e);
   endtask
   task automatic mc(input int cnt, input logic [32:0] e0, input logic [32:0] e1);
      chk(33'(mem_model_i.hist.size()), 33'(cnt));
      if (cnt > 0) chk(mem_model_i.hist[0], e0);
      if (cnt > 1) chk(mem_model_i.hist[1], e1);
      mem_model_i.hist.delete();
   endtask
   initial begin
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      acc(0, REG_CTRL, 0);
      chk(rd, 0);
      acc(0, 4'h2, 0);
      chk(rd, 0);
      acc(1, REG_CTRL, 32'h30);
      acc(0, REG_CTRL, 0);
      chk(rd[5:4], 0);
      mem_model_i.hist.delete();
      op(0, OP_READ, 0, A, 0);
      chk(rd, 32'hd000_0010);
      mc(1, A, 0);
      op(0, OP_READ, 0, A, 0);
      mc(0, 0, 0);
      sc(3'b110);
      op(0, OP_WRITE, 0, B, 32'h11);
      mc(1, {1'b1, B}, 0);
      op(0, OP_READ, 0, B, 0);
      chk(rd, 32'h11);
      mc(1, B, 0);
      op(0, OP_WRITE, 0, A, 32'h22);
      mc(1, {1'b1, A}, 0);
      op(0, OP_READ, 0, A, 0);
      chk(rd, 32'h22);
      sc(3'b110);
      acc(1, REG_CTRL, 32'h1);
      op(0, OP_WRITE, 0, A, 32'h33);
      repeat (2) begin
         op(0, OP_READ, 0, A, 0);
         chk(rd, 32'h33);
         sc(3'b111);
      end
      mc(0, 0, 0);
      op(0, OP_WRITE, 0, C, 32'h44);
      mc(1, C, 0);
      op(0, OP_READ, 0, C, 0);
      chk(rd, 32'h44);
      sc(3'b111);
      op(0, OP_READ, 0, D, 0);
      mc(1, D, 0);
      @(posedge sys_clk) slow <= 1'b1;
      op(0, OP_READ, 0, E, 0);
      chk(rd, 32'hd000_0050);
      mc(2, E, {1'b1, A});
      chk(mem_model_i.words[A], 32'h33);
      op(0, OP_READ, 0, F, 0);
      mc(1, F, 0);
      op(0, OP_READ, 0, A, 0);
      chk(rd, 32'h33);
      mc(2, A, {1'b1, C});
      @(posedge sys_clk) slow <= 1'b0;
      op(0, OP_WRITE, 0, E, 32'h55);
      acc(1, REG_CTRL, 32'h5);
      op(0, OP_PUSH, 0, E, 0);
      mc(1, {1'b1, E}, 0);
      chk(mem_model_i.words[E], 32'h55);
      op(0, OP_READ, 0, E, 0);
      sc(3'b110);
      op(0, OP_WRITE, 0, E, 32'h66);
      acc(1, REG_CTRL, 32'h1);
      op(0, OP_PUSH, 0, E, 0);
      op(0, OP_READ, 0, E, 0);
      chk(rd, 32'h66);
      mc(2, {1'b1, E}, E);
      op(0, OP_WRITE, 0, F, 32'h77);
      op(0, OP_INVALIDATE, 1, F, 0);
      op(0, OP_READ, 0, F, 0);
      chk(rd, 32'hd000_0060);
      mc(1, F, 0);
      op(1, OP_READ, 0, A, 0);
      chk(rd, 32'h33);
      op(1, OP_READ, 0, A, 0);
      sc(3'b110);
      op(1, OP_WRITE, 0, A, 32'h99);
      op(1, OP_READ, 0, A, 0);
      chk(rd, 32'h33);
      mc(1, A, 0);
      op(1, OP_INVALIDATE, 0, A, 0);
      op(1, OP_READ, 0, A, 0);
      mc(1, A, 0);
      acc(1, REG_CTRL, 32'h0);
      for (int m = 0; m < 4; m++) begin
         a = 32'h84 + 32'(m) * 32'h10;
         acc(1, REG_REGION0, 32'h8000 | (32'(m) << 5));
         op(0, OP_READ, 0, a, 0);
         mem_model_i.hist.delete();
         op(0, OP_READ, 0, a, 0);
         op(0, OP_WRITE, 0, a, 32'h1);
         chk(33'(mem_model_i.hist.size()), 33'(m == 0 ? 1 : m == 1 ? 0 : 2));
         mem_model_i.hist.delete();
         if (m == 1) acc(1, REG_CTRL, 32'h10);
      end
      complete_run();
   end
endmodule
`default_nettype wire
